// [include/pwr_cfg_pkg.sv]
// Constants of the power-mode configuration block.
// Assumes a 20 MHz system clock and a word-wide register port.
package pwr_cfg_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CONV_SLOW_US = 3000;
  localparam int CONV_FAST_US = 1500;
  localparam int WAKE_BASE_US = 6000;
  localparam int CONV_SLOW_CYC = CONV_SLOW_US * CLK_MHZ;
  localparam int CONV_FAST_CYC = CONV_FAST_US * CLK_MHZ;
  localparam int WAKE_BASE_CYC = WAKE_BASE_US * CLK_MHZ;
  localparam int NCELL = 4;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [15:0] CFG_RESET = 16'h2982;
  localparam logic [15:0] CFG_WMASK = 16'h3fff;
  localparam int B_OT = 13;
  localparam int B_EDGE_WAIT = 12;
  localparam int B_EDGE_WAKE = 11;
  localparam int B_KEEP_REG = 10;
  localparam int B_KEEP_OSC = 9;
  localparam int B_SLEEP = 8;
  localparam int B_OVERTEMP_POWEROFF_ENABLE = 7;
  localparam int B_QUICK = 6;
  localparam int B_BAL_DIV = 4;
  localparam int B_NORM_DIV = 2;
  localparam int B_WAKE = 0;
  localparam int C_DEEP_ENTER = 0;
  localparam int C_DEEP_EXIT = 1;
  localparam int C_SLEEP_ALLOW = 2;
  localparam int C_SLEEP_FORBID = 3;
  localparam int C_REINIT = 4;
  localparam int C_REGA_ON = 5;
  localparam int C_REGA_OFF = 6;
  localparam int C_REGB_ON = 7;
  localparam int C_REGB_OFF = 8;
  typedef enum logic [4:0] {
    M_NORMAL = 5'h01,
    M_SLEEP = 5'h02,
    M_DEEP = 5'h04,
    M_EDGE_WAIT = 5'h08,
    M_OFF = 5'h10
  } mode_t;
endpackage : pwr_cfg_pkg

// [src/scan_pacer.sv]
// ADC scan pacing: conversion ticks, voltage loop and current-only fill.
// Assumes run is a same-clock level and dividers change between loops.
module scan_pacer #(
  parameter int CONV_SLOW = pwr_cfg_pkg::CONV_SLOW_CYC,
  parameter int CONV_FAST = pwr_cfg_pkg::CONV_FAST_CYC,
  parameter int CELLS = pwr_cfg_pkg::NCELL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic quick,
  input wire logic balancing,
  input wire logic [1:0] bal_div,
  input wire logic [1:0] norm_div,
  // Pacing
  output logic conv_tick,
  output logic voltage_phase,
  output logic [$clog2(CELLS)-1:0] cell_idx
);
  import pwr_cfg_pkg::*;
  localparam int TW = $clog2(CONV_SLOW + 1);
  localparam int CW = $clog2(CELLS);
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] slot_r, slot_nxt;
  logic [2:0] loop_r, loop_nxt;
  logic [2:0] loop_last;
  logic tick;

  // RULE_09 divider while balancing
  // RULE_10 divider otherwise
  assign loop_last = balancing ? 3'((1 << bal_div) - 1) : 3'((1 << norm_div) - 1);
  assign tick = run && (tmr_r == '0);

  always_comb begin
    tmr_nxt = tmr_r;
    slot_nxt = slot_r;
    loop_nxt = loop_r;
    if (!run) begin
      tmr_nxt = '0;
      slot_nxt = '0;
      loop_nxt = '0;
    end else if (tick) begin
      // RULE_08 conversion time
      tmr_nxt = quick ? TW'(CONV_FAST - 1) : TW'(CONV_SLOW - 1);
      if (slot_r == CW'(CELLS - 1)) begin
        slot_nxt = '0;
        loop_nxt = (loop_r >= loop_last) ? 3'h0 : 3'(loop_r + 3'h1);
      end else begin
        slot_nxt = CW'(slot_r + 1'b1);
      end
    end else begin
      tmr_nxt = TW'(tmr_r - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tmr_r <= '0;
      slot_r <= '0;
      loop_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
      slot_r <= slot_nxt;
      loop_r <= loop_nxt;
    end
  end

  assign conv_tick = tick;
  assign voltage_phase = run && (loop_r == 3'h0);
  assign cell_idx = slot_r;
endmodule : scan_pacer

// [src/wake_timer.sv]
// Coulomb-counter conversion ticks for the sleep current-wake check.
// Assumes run is a same-clock level; rate is a stable setting.
module wake_timer #(
  parameter int BASE = pwr_cfg_pkg::WAKE_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [1:0] rate,
  // Tick
  output logic tick
);
  import pwr_cfg_pkg::*;
  localparam int W = $clog2(BASE * 8 + 1);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic [W-1:0] last;

  // RULE_12 48, 24, 12, 6 ms
  assign last = W'((BASE << (2'd3 - rate)) - 1);
  assign tick = run && (cnt_r >= last);

  always_comb begin
    cnt_nxt = '0;
    if (run && !tick) begin
      cnt_nxt = W'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : wake_timer

// [src/power_mode_config.sv]
// Power-mode configuration word, mode sequencer and pacing outputs.
// Assumes async pins are synchronised here; other inputs are on clk.
// Summary of operation
// RULE_01 - Bit 13 keeps overtemperature detection alive in deep idle and lets it lead to power-off.
// RULE_02 - Bit 12 turns every power-off into a low-power wait for a load-detect rising edge.
// RULE_03 - Bit 11 lets a load-detect rising edge end deep idle, otherwise only a host command does.
// RULE_04 - Bit 10 clear switches both auxiliary regulators off when deep idle is entered.
// RULE_05 - Bit 9 clear stops the slow oscillator during deep idle.
// RULE_06 - The sleep-allowed flag loads from bit 8 at initialization and then follows the allow and forbid commands.
// RULE_07 - Bit 7 set sends the device to power-off on a severe on-chip overtemperature.
// RULE_08 - Bit 6 picks 3 ms or 1.5 ms per conversion.
// RULE_09 - Bits 5 to 4 slow the scan loop while balancing by current-only loops.
// RULE_10 - Bits 3 to 2 slow the scan loop in the same way while not balancing.
// RULE_11 - Balancing of a cell pauses while that cell is being measured.
// RULE_12 - In sleep the wake counter converts every 48, 24, 12 or 6 ms by bits 1 to 0.
// RULE_13 - Software should avoid wake code 2 and use code 3 only for large wake thresholds.
// RULE_14 - The word resets to 0x2982 and bits 15 and 14 stay zero.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
module power_mode_config #(
  parameter int CONV_SLOW = pwr_cfg_pkg::CONV_SLOW_CYC,
  parameter int CONV_FAST = pwr_cfg_pkg::CONV_FAST_CYC,
  parameter int WAKE_BASE = pwr_cfg_pkg::WAKE_BASE_CYC,
  parameter int CELLS = pwr_cfg_pkg::NCELL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Pins and analog flags, asynchronous
  input wire logic load_detect_pin,
  input wire logic overtemp_flag,
  input wire logic severe_overtemp_flag,
  // Same-clock requests
  input wire logic poweroff_request,
  input wire logic sleep_request,
  input wire logic wake_event,
  input wire logic [CELLS-1:0] balance_request,
  // Mode and power controls
  output pwr_cfg_pkg::mode_t mode,
  output logic sleep_allowed,
  output logic aux_regulator_a,
  output logic aux_regulator_b,
  output logic slow_osc_enable,
  output logic overtemp_detect_enable,
  // Measurement pacing
  output logic conv_tick,
  output logic voltage_phase,
  output logic [$clog2(CELLS)-1:0] cell_idx,
  output logic [CELLS-1:0] balance_enable,
  output logic wake_conv_tick
);
  import pwr_cfg_pkg::*;
  logic [15:0] cfg_r, cfg_nxt;
  mode_t mode_r, mode_nxt;
  logic sleep_ok_r, sleep_ok_nxt;
  logic rega_r, rega_nxt, regb_r, regb_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] s1_r, s2_r;
  logic ld_prev_r;
  logic ld_rise, ot_s, sot_s;
  logic cfg_wr, cmd_wr;
  logic [15:0] cmd;
  mode_t off_target;
  logic [CELLS-1:0] bal_r, bal_nxt;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      ld_prev_r <= 1'b0;
    end else begin
      s1_r <= {severe_overtemp_flag, overtemp_flag, load_detect_pin};
      s2_r <= s1_r;
      ld_prev_r <= s2_r[0];
    end
  end
  assign ld_rise = s2_r[0] && !ld_prev_r;
  assign ot_s = s2_r[1];
  assign sot_s = s2_r[2];

  assign cfg_wr = wr && (addr == OFS_CFG);
  assign cmd_wr = wr && (addr == OFS_CMD);
  assign cmd = cmd_wr ? wdata[15:0] : 16'h0000;

  // RULE_02 power-off or edge wait
  assign off_target = cfg_r[B_EDGE_WAIT] ? M_EDGE_WAIT : M_OFF;

  // Register file
  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = 32'h0000_0000;
    // RULE_14 reserved bits held zero
    if (cfg_wr) begin
      cfg_nxt = wdata[15:0] & CFG_WMASK;
    end
    if (rd) begin
      if (addr == OFS_CFG) begin
        rdata_nxt = {16'h0000, cfg_r};
      end else if (addr == OFS_STATUS) begin
        rdata_nxt = {24'h000000, regb_r, rega_r, sleep_ok_r, mode_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // RULE_14 reset value
      cfg_r <= CFG_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // Mode sequencer
  always_comb begin
    mode_nxt = mode_r;
    sleep_ok_nxt = sleep_ok_r;
    rega_nxt = rega_r;
    regb_nxt = regb_r;
    // RULE_06 host sleep allow and forbid
    if (cmd[C_REINIT]) begin
      sleep_ok_nxt = cfg_r[B_SLEEP];
    end else if (cmd[C_SLEEP_ALLOW]) begin
      sleep_ok_nxt = 1'b1;
    end else if (cmd[C_SLEEP_FORBID]) begin
      sleep_ok_nxt = 1'b0;
    end
    if (cmd[C_REGA_ON]) begin
      rega_nxt = 1'b1;
    end else if (cmd[C_REGA_OFF]) begin
      rega_nxt = 1'b0;
    end
    if (cmd[C_REGB_ON]) begin
      regb_nxt = 1'b1;
    end else if (cmd[C_REGB_OFF]) begin
      regb_nxt = 1'b0;
    end
    case (mode_r)
      M_NORMAL: begin
        if (cmd[C_DEEP_ENTER]) begin
          mode_nxt = M_DEEP;
        end else if (sleep_request && sleep_ok_r) begin
          mode_nxt = M_SLEEP;
        end
      end
      M_SLEEP: begin
        if (cmd[C_DEEP_ENTER]) begin
          mode_nxt = M_DEEP;
        end else if (wake_event || !sleep_ok_r) begin
          mode_nxt = M_NORMAL;
        end
      end
      M_DEEP: begin
        // RULE_01 overtemp exit from deep idle
        if (cfg_r[B_OT] && ot_s) begin
          mode_nxt = off_target;
        // RULE_03 edge or host exit
        end else if (cmd[C_DEEP_EXIT] || (cfg_r[B_EDGE_WAKE] && ld_rise)) begin
          mode_nxt = M_NORMAL;
        end
      end
      M_EDGE_WAIT: begin
        if (ld_rise) begin
          mode_nxt = M_NORMAL;
        end
      end
      M_OFF: begin
        mode_nxt = M_OFF;
      end
      default: begin
        mode_nxt = M_NORMAL;
      end
    endcase
    // RULE_07 severe overtemp power_off_mode
    if (mode_r != M_OFF && mode_r != M_EDGE_WAIT) begin
      if (poweroff_request || (cfg_r[B_OVERTEMP_POWEROFF_ENABLE] && sot_s)) begin
        mode_nxt = off_target;
      end
    end
    // RULE_04 regulators off on deep idle entry
    if (mode_nxt == M_DEEP && mode_r != M_DEEP && !cfg_r[B_KEEP_REG]) begin
      rega_nxt = 1'b0;
      regb_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= M_NORMAL;
      // RULE_06 load at initialization
      sleep_ok_r <= CFG_RESET[B_SLEEP];
      rega_r <= 1'b0;
      regb_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      sleep_ok_r <= sleep_ok_nxt;
      rega_r <= rega_nxt;
      regb_r <= regb_nxt;
    end
  end

  assign mode = mode_r;
  assign sleep_allowed = sleep_ok_r;
  assign aux_regulator_a = rega_r;
  assign aux_regulator_b = regb_r;
  // RULE_05 slow oscillator gating
  assign slow_osc_enable = (mode_r != M_OFF) && !(mode_r == M_DEEP && !cfg_r[B_KEEP_OSC]);
  // RULE_01 detector alive in deep idle
  assign overtemp_detect_enable = (mode_r == M_NORMAL) || (mode_r == M_SLEEP) ||
                                  (mode_r == M_DEEP && cfg_r[B_OT]);

  // Scans run only in normal mode; sleep uses the wake counter
  scan_pacer #(
    .CONV_SLOW(CONV_SLOW),
    .CONV_FAST(CONV_FAST),
    .CELLS(CELLS)
  ) u_pacer (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(mode_r == M_NORMAL),
    .quick(cfg_r[B_QUICK]),
    .balancing(|balance_request),
    .bal_div(cfg_r[B_BAL_DIV +: 2]),
    .norm_div(cfg_r[B_NORM_DIV +: 2]),
    .conv_tick(conv_tick),
    .voltage_phase(voltage_phase),
    .cell_idx(cell_idx)
  );

  wake_timer #(
    .BASE(WAKE_BASE)
  ) u_wake (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(mode_r == M_SLEEP),
    .rate(cfg_r[B_WAKE +: 2]),
    .tick(wake_conv_tick)
  );

  // RULE_11 pause balancing on measured cell
  always_comb begin
    bal_nxt = balance_request;
    if (voltage_phase) begin
      bal_nxt[cell_idx] = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bal_r <= '0;
    end else begin
      bal_r <= bal_nxt;
    end
  end
  assign balance_enable = bal_r;

  // Checks
  property p_reset_val;
    @(posedge clk) $fell(sys_rst) |-> (cfg_r == 16'h2982);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("config reset value wrong"); // RULE_14
  property p_rsvd;
    @(posedge clk) disable iff (sys_rst) cfg_r[15:14] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved config bits set"); // RULE_14
  property p_ot_deep;
    @(posedge clk) disable iff (sys_rst)
      (mode_r == M_DEEP && cfg_r[B_OT] && ot_s && !cfg_r[B_EDGE_WAIT]) |=> (mode_r == M_OFF);
  endproperty
  a_ot_deep: assert property (p_ot_deep) else $error("deep idle overtemp not to power-off"); // RULE_01
  property p_no_ot_deep;
    @(posedge clk) disable iff (sys_rst)
      (mode_r == M_DEEP && !cfg_r[B_OT]) |-> !overtemp_detect_enable;
  endproperty
  a_no_ot_deep: assert property (p_no_ot_deep) else $error("detector on in deep idle"); // RULE_01
  property p_edge_wait;
    @(posedge clk) disable iff (sys_rst)
      (poweroff_request && cfg_r[B_EDGE_WAIT] && mode_r == M_NORMAL) |=> (mode_r == M_EDGE_WAIT);
  endproperty
  a_edge_wait: assert property (p_edge_wait) else $error("edge wait not entered"); // RULE_02
  property p_deep_stay;
    @(posedge clk) disable iff (sys_rst)
      (mode_r == M_DEEP && !cfg_r[B_EDGE_WAKE] && !cmd[C_DEEP_EXIT] && !ot_s && !sot_s && !poweroff_request)
      |=> (mode_r == M_DEEP);
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("deep idle left without cause"); // RULE_03
  property p_reg_off;
    @(posedge clk) disable iff (sys_rst)
      ($past(mode_r) != M_DEEP && mode_r == M_DEEP && !$past(cfg_r[B_KEEP_REG])) |-> !(rega_r || regb_r);
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulators left on in deep idle"); // RULE_04
  property p_osc;
    @(posedge clk) disable iff (sys_rst)
      (mode_r == M_DEEP) |-> (slow_osc_enable == cfg_r[B_KEEP_OSC]);
  endproperty
  a_osc: assert property (p_osc) else $error("slow oscillator gating wrong"); // RULE_05
  property p_sleep_allow;
    @(posedge clk) disable iff (sys_rst)
      (cmd[C_SLEEP_ALLOW] && !cmd[C_REINIT]) |=> sleep_ok_r;
  endproperty
  a_sleep_allow: assert property (p_sleep_allow) else $error("sleep allow ignored"); // RULE_06
  property p_overtemp_poweroff_enable;
    @(posedge clk) disable iff (sys_rst)
      (cfg_r[B_OVERTEMP_POWEROFF_ENABLE] && sot_s && !cfg_r[B_EDGE_WAIT] && mode_r != M_EDGE_WAIT) |=> (mode_r == M_OFF);
  endproperty
  a_overtemp_poweroff_enable: assert property (p_overtemp_poweroff_enable) else $error("severe overtemp not handled"); // RULE_07
  property p_bal_pause;
    @(posedge clk) disable iff (sys_rst)
      voltage_phase |=> !bal_r[$past(cell_idx)];
  endproperty
  a_bal_pause: assert property (p_bal_pause) else $error("balancing during measurement"); // RULE_11
  property p_wake_idle;
    @(posedge clk) disable iff (sys_rst) (mode_r != M_SLEEP) |-> !wake_conv_tick;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("wake tick outside sleep"); // RULE_12
  c_deep: cover property (@(posedge clk) disable iff (sys_rst) mode_r == M_DEEP ##1 mode_r == M_NORMAL);
  c_sleep: cover property (@(posedge clk) disable iff (sys_rst) mode_r == M_SLEEP && wake_conv_tick);
  c_edge: cover property (@(posedge clk) disable iff (sys_rst) mode_r == M_EDGE_WAIT ##1 mode_r == M_NORMAL);
endmodule : power_mode_config

// [tb/tb_power_mode_config.sv]
// Self-checking bench for the power-mode configuration block.
// Assumes shortened pacing parameters below; the bench drives every port itself.
module tb_power_mode_config import pwr_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run small; expectations derive from these
  localparam int SLOW = 20;
  localparam int FAST = 10;
  localparam int WBASE = 8;
  logic clk, sys_rst, wr, rd, ld, ot, sev, poff, slp, wake;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] breq, ben;
  mode_t mode;
  logic sa, rega, regb, osc, oten, ct, vp, wt;
  logic [1:0] cidx;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // Config write value and expected readback
  logic [63:0] rows [4] = '{64'h0000ffff_00003fff, 64'hffffc000_00000000,
                            64'h12345a5a_00001a5a, 64'h00000782_00000782};

  power_mode_config #(.CONV_SLOW(SLOW), .CONV_FAST(FAST), .WAKE_BASE(WBASE), .CELLS(4)) power_mode_config_i (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .load_detect_pin(ld), .overtemp_flag(ot), .severe_overtemp_flag(sev), .poweroff_request(poff),
    .sleep_request(slp), .wake_event(wake), .balance_request(breq), .mode(mode), .sleep_allowed(sa),
    .aux_regulator_a(rega), .aux_regulator_b(regb), .slow_osc_enable(osc), .overtemp_detect_enable(oten),
    .conv_tick(ct), .voltage_phase(vp), .cell_idx(cidx), .balance_enable(ben), .wake_conv_tick(wt));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task end_of_test;
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  task step;
    @(posedge clk);
    #1;
  endtask : step

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_w(rdata, exp);
  endtask : rreg

  task wait_mode(input mode_t m);
    int k;
    step;
    for (k = 0; k < 8 && mode !== m; k++) step;
    chk_w(32'(mode), 32'(m));
    if (k == 8) end_of_test;
  endtask : wait_mode

  task hold_mode(input mode_t m);
    repeat (8) step;
    chk_w(32'(mode), 32'(m));
  endtask : hold_mode

  // Pin is synchronised inside, so hold it long enough both ways
  task ld_pulse;
    @(posedge clk);
    ld <= 1'b1;
    repeat (6) @(posedge clk);
    ld <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : ld_pulse

  function automatic logic sig(input int s);
    case (s)
      0: return ct;
      1: return wt;
      default: return vp;
    endcase
  endfunction : sig

  task rise(input int s);
    int k;
    k = 0;
    step;
    while (k < 3000 && sig(s) !== 1'b0) begin
      step;
      k++;
    end
    while (k < 3000 && sig(s) !== 1'b1) begin
      step;
      k++;
    end
    if (k >= 3000) begin
      bad_count++;
      end_of_test;
    end
  endtask : rise

  // First interval may straddle a setting change, so skip it
  task period(input int s, input int exp);
    int c0;
    rise(s);
    rise(s);
    c0 = cyc;
    rise(s);
    chk_n(cyc - c0, exp);
  endtask : period

  task do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_of_test;
  end

  initial begin
    sys_rst = 1'b1;
    {wr, rd, ld, ot, sev, poff, slp, wake} = 8'h00;
    addr = 8'h00;
    wdata = 32'h0;
    breq = 4'h0;
    do_reset;
    foreach (rows[i]) begin
      wreg(OFS_CFG, rows[i][63:32]);
      rreg(OFS_CFG, rows[i][31:0]);
    end
    do_reset;
    rreg(OFS_CFG, 32'h2982);
    rreg(OFS_STATUS, 32'h21);
    rreg(8'h0c, 32'h0);
    rreg(OFS_CMD, 32'h0);
    period(0, SLOW);
    wreg(OFS_CFG, 32'h29c2);
    period(0, FAST);
    @(posedge clk);
    breq <= 4'hf;
    wreg(OFS_CFG, 32'h29e2);
    period(2, 16 * FAST);
    rise(2);
    rise(0);
    repeat (5) step;
    chk_w(32'(vp), 32'h1);
    chk_w(32'(cidx), 32'h1);
    chk_w(32'(ben), 32'hd);
    @(posedge clk);
    breq <= 4'h0;
    wreg(OFS_CFG, 32'h298e);
    period(2, 32 * SLOW);
    wreg(OFS_CMD, 32'ha0);
    rreg(OFS_STATUS, 32'he1);
    wreg(OFS_CMD, 32'h1);
    wait_mode(M_DEEP);
    rreg(OFS_STATUS, 32'h24);
    chk_w(32'({regb, rega, sa}), 32'h1);
    chk_w(32'(osc), 32'h0);
    chk_w(32'(oten), 32'h1);
    ld_pulse;
    wait_mode(M_NORMAL);
    wreg(OFS_CFG, 32'h0782);
    wreg(OFS_CMD, 32'ha0);
    wreg(OFS_CMD, 32'h1);
    wait_mode(M_DEEP);
    rreg(OFS_STATUS, 32'he4);
    chk_w(32'(osc), 32'h1);
    chk_w(32'(oten), 32'h0);
    chk_w(32'({regb, rega, sa}), 32'h7);
    wreg(OFS_CMD, 32'h140);
    rreg(OFS_STATUS, 32'h24);
    chk_w(32'({regb, rega}), 32'h0);
    ld_pulse;
    hold_mode(M_DEEP);
    @(posedge clk);
    ot <= 1'b1;
    hold_mode(M_DEEP);
    @(posedge clk);
    ot <= 1'b0;
    wreg(OFS_CMD, 32'h2);
    wait_mode(M_NORMAL);
    wreg(OFS_CFG, 32'h3982);
    wreg(OFS_CMD, 32'h1);
    wait_mode(M_DEEP);
    @(posedge clk);
    ot <= 1'b1;
    wait_mode(M_EDGE_WAIT);
    @(posedge clk);
    ot <= 1'b0;
    ld_pulse;
    wait_mode(M_NORMAL);
    wreg(OFS_CMD, 32'h8);
    rreg(OFS_STATUS, 32'h01);
    chk_w(32'(sa), 32'h0);
    @(posedge clk);
    slp <= 1'b1;
    hold_mode(M_NORMAL);
    wreg(OFS_CMD, 32'h4);
    wait_mode(M_SLEEP);
    for (int c = 0; c < 4; c++) begin
      wreg(OFS_CFG, 32'h3980 | 32'(c));
      period(1, WBASE << (3 - c));
    end
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_mode(M_NORMAL);
    wreg(OFS_CFG, 32'h2882);
    wreg(OFS_CMD, 32'h10);
    rreg(OFS_STATUS, 32'h01);
    wreg(OFS_CFG, 32'h2902);
    wreg(OFS_CMD, 32'h10);
    rreg(OFS_STATUS, 32'h21);
    @(posedge clk);
    sev <= 1'b1;
    hold_mode(M_NORMAL);
    @(posedge clk);
    sev <= 1'b0;
    wreg(OFS_CFG, 32'h3982);
    poff <= 1'b1;
    @(posedge clk);
    poff <= 1'b0;
    wait_mode(M_EDGE_WAIT);
    ld_pulse;
    wait_mode(M_NORMAL);
    wreg(OFS_CFG, 32'h2982);
    sev <= 1'b1;
    wait_mode(M_OFF);
    @(posedge clk);
    sev <= 1'b0;
    ld_pulse;
    hold_mode(M_OFF);
    do_reset;
    step;
    chk_w(32'(mode), 32'(M_NORMAL));
    wreg(OFS_CMD, 32'h1);
    wait_mode(M_DEEP);
    @(posedge clk);
    ot <= 1'b1;
    wait_mode(M_OFF);
    end_of_test;
  end
endmodule : tb_power_mode_config
